// ===== hw/itdst_regs.sv
/*
  Inductance threshold registers, comparator flags and status register.
  Assumes register accesses and conversion results come from logic on clk.
*/
`timescale 1ns/10ps
module itdst_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register access port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Conversion core
  input  wire logic        conv_done,
  input  wire logic [15:0] ind_result,
  input  wire logic [15:0] res_result,
  input  wire logic [15:0] res_upper_limit,
  input  wire logic [15:0] res_lower_limit,
  input  wire logic        no_oscillation_error,
  // Configuration outputs
  output logic      [15:0] ind_upper_limit,
  output logic      [15:0] ind_lower_limit,
  output logic      [5:0]  irq_source_select,
  output logic             config_ready
);

  itdst_pkg::itdst_por_e                por_state_q;
  logic [itdst_pkg::POR_CNT_W-1:0]      por_cnt_q;
  logic                                 wr_ok;
  logic [7:0]                           up_low_byte;
  logic [7:0]                           low_low_byte;
  logic                                 ind_hi_n_q;
  logic                                 ind_hyst_q;
  logic                                 res_hi_n_q;
  logic                                 res_hyst_q;
  logic                                 ready_n_q;
  logic [7:0]                           status_q;
  logic [7:0]                           status_d;
  logic [7:0]                           rdata_d;
  logic                                 latch_clear;
  logic                                 status_read;

  // Qualifier and address are arguments, so continuous uses see every change of them.
  function automatic logic wr_to(input logic       ok,
                                 input logic [7:0] addr,
                                 input logic [7:0] target);
    wr_to = ok && (addr == target);
  endfunction : wr_to

  // Configuration is refused until the power-on sequence has settled.
  assign wr_ok       = reg_wr && (por_state_q == itdst_pkg::POR_DONE);
  assign latch_clear = wr_to(wr_ok, reg_addr, itdst_pkg::ADDR_IRQ_SEL) &&
                       (reg_wdata == itdst_pkg::LATCH_CLEAR);
  assign status_read = reg_rd && (reg_addr == itdst_pkg::ADDR_STATUS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_state_q <= itdst_pkg::POR_HOLD;
      por_cnt_q   <= itdst_pkg::POR_CNT_RESET;
    end else begin
      case (por_state_q)
        itdst_pkg::POR_HOLD: begin
          if (por_cnt_q == itdst_pkg::POR_LAST) begin
            por_state_q <= itdst_pkg::POR_DONE;
          end else begin
            por_cnt_q <= por_cnt_q + 7'h01;
          end
        end
        itdst_pkg::POR_DONE: begin
          por_state_q <= itdst_pkg::POR_DONE;
        end
        default: begin
          por_state_q <= itdst_pkg::POR_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_ready <= 1'b0;
    end else begin
      config_ready <= (por_state_q == itdst_pkg::POR_DONE);
    end
  end

  // Writes land whatever the conversion mode; no mode change is implied.
  itdst_limit_pair u_upper (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_low   (wr_to(wr_ok, reg_addr, itdst_pkg::ADDR_IND_UP_LO)),
    .wr_high  (wr_to(wr_ok, reg_addr, itdst_pkg::ADDR_IND_UP_HI)),
    .wdata    (reg_wdata),
    .low_byte (up_low_byte),
    .limit    (ind_upper_limit)
  );

  itdst_limit_pair u_lower (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_low   (wr_to(wr_ok, reg_addr, itdst_pkg::ADDR_IND_LOW_LO)),
    .wr_high  (wr_to(wr_ok, reg_addr, itdst_pkg::ADDR_IND_LOW_HI)),
    .wdata    (reg_wdata),
    .low_byte (low_low_byte),
    .limit    (ind_lower_limit)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_source_select <= itdst_pkg::IRQ_SEL_RESET;
    end else if (wr_to(wr_ok, reg_addr, itdst_pkg::ADDR_IRQ_SEL)) begin
      irq_source_select <= reg_wdata[5:0];
    end
  end

  // A crossing in the same cycle as the clear wins, so no event is lost.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ind_hi_n_q <= 1'b1;
      res_hi_n_q <= 1'b1;
    end else begin
      if (conv_done && (ind_result > ind_upper_limit)) begin
        ind_hi_n_q <= 1'b0;
      end else if (latch_clear) begin
        ind_hi_n_q <= 1'b1;
      end
      if (conv_done && (res_result > res_upper_limit)) begin
        res_hi_n_q <= 1'b0;
      end else if (latch_clear) begin
        res_hi_n_q <= 1'b1;
      end
    end
  end

  // Between the two thresholds each hysteresis flag keeps its last value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ind_hyst_q <= 1'b0;
      res_hyst_q <= 1'b0;
    end else if (conv_done) begin
      if (ind_result < ind_lower_limit) begin
        ind_hyst_q <= 1'b1;
      end else if (ind_result > ind_upper_limit) begin
        ind_hyst_q <= 1'b0;
      end
      if (res_result < res_lower_limit) begin
        res_hyst_q <= 1'b1;
      end else if (res_result > res_upper_limit) begin
        res_hyst_q <= 1'b0;
      end
    end
  end

  // Reading the status consumes the result; a new one arriving then wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_n_q <= 1'b1;
    end else if (conv_done) begin
      ready_n_q <= 1'b0;
    end else if (status_read) begin
      ready_n_q <= 1'b1;
    end
  end

  always_comb begin
    status_d = itdst_pkg::STATUS_RESET;
    status_d[itdst_pkg::ST_NO_OSC]   = no_oscillation_error;
    status_d[itdst_pkg::ST_READY_N]  = ready_n_q;
    status_d[itdst_pkg::ST_RES_HI_N] = (irq_source_select == itdst_pkg::SEL_RES_LATCH) ?
                                       res_hi_n_q : 1'b1;
    status_d[itdst_pkg::ST_RES_HYST] = res_hyst_q;
    status_d[itdst_pkg::ST_IND_HI_N] = (irq_source_select == itdst_pkg::SEL_IND_LATCH) ?
                                       ind_hi_n_q : 1'b1;
    status_d[itdst_pkg::ST_IND_HYST] = ind_hyst_q;
    status_d[itdst_pkg::ST_UNUSED]   = 1'b0;
    status_d[itdst_pkg::ST_POR]      = (por_state_q == itdst_pkg::POR_HOLD);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= itdst_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // The status register has no write path at all.
  always_comb begin
    case (reg_addr)
      itdst_pkg::ADDR_IRQ_SEL:    rdata_d = {2'b00, irq_source_select};
      itdst_pkg::ADDR_IND_UP_LO:  rdata_d = up_low_byte;
      itdst_pkg::ADDR_IND_UP_HI:  rdata_d = ind_upper_limit[15:8];
      itdst_pkg::ADDR_IND_LOW_LO: rdata_d = low_low_byte;
      itdst_pkg::ADDR_IND_LOW_HI: rdata_d = ind_lower_limit[15:8];
      itdst_pkg::ADDR_STATUS:     rdata_d = status_q;
      default:                    rdata_d = itdst_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= itdst_pkg::BYTE_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence low_hi_write_s;
    wr_ok && (reg_addr == itdst_pkg::ADDR_IND_LOW_HI);
  endsequence

  sequence ind_below_s;
    conv_done && (ind_result < ind_lower_limit);
  endsequence

  sequence ind_above_s;
    conv_done && (ind_result > ind_upper_limit);
  endsequence

  lower_commit_a: assert property (low_hi_write_s |=>
    ind_lower_limit == {$past(reg_wdata), $past(low_low_byte)})
    else $error("lower threshold not committed from buffered low byte");

  lower_buffer_a: assert property (
    (wr_ok && (reg_addr == itdst_pkg::ADDR_IND_LOW_LO)) |=> $stable(ind_lower_limit))
    else $error("lower threshold changed on low byte write");

  upper_commit_a: assert property (
    (wr_ok && (reg_addr == itdst_pkg::ADDR_IND_UP_HI)) |=>
    ind_upper_limit == {$past(reg_wdata), $past(up_low_byte)})
    else $error("upper threshold not committed from buffered low byte");

  hyst_status_a: assert property (ind_below_s |=> ind_hyst_q ##1 status_q[2])
    else $error("hysteresis flag not raised below lower threshold");

  high_latch_a: assert property (ind_above_s |=> !ind_hi_n_q)
    else $error("high latch not low after exceeding upper threshold");

  latch_clear_a: assert property (
    (latch_clear && !(conv_done && (res_result > res_upper_limit))) |=> res_hi_n_q)
    else $error("resistance latch not cleared by zero write");

  por_refuse_a: assert property ((reg_wr && !config_ready && status_d[0]) |=>
    $stable(irq_source_select) && $stable(ind_lower_limit) && $stable(ind_upper_limit))
    else $error("configuration changed during power-on");

  ready_flag_a: assert property (conv_done |=> !ready_n_q ##1 !status_q[6])
    else $error("ready flag not low after conversion");

  unused_bit_a: assert property (status_q[1] == 1'b0)
    else $error("status bit 1 not zero");

  hyst_clear_a: assert property (
    (conv_done && (ind_result > ind_upper_limit) && (ind_result >= ind_lower_limit)) |=>
    !ind_hyst_q)
    else $error("hysteresis flag not cleared above upper threshold");

  osc_status_a: assert property (
    1'b1 |=> (status_q[itdst_pkg::ST_NO_OSC] == $past(no_oscillation_error)))
    else $error("status bit 7 does not follow the oscillation error");

  por_status_a: assert property (
    (por_state_q == itdst_pkg::POR_DONE) |=> !status_q[itdst_pkg::ST_POR])
    else $error("status bit 0 still high after power-on");

  sel_hidden_a: assert property (
    (irq_source_select != itdst_pkg::SEL_IND_LATCH) |=> status_q[itdst_pkg::ST_IND_HI_N])
    else $error("inductance latch shown without its selection");

endmodule : itdst_regs

// ===== inc/itdst_pkg.sv
/*
  Shared constants, types and helpers for the inductance threshold and status
  register block. Assumes a single 250 MHz device clock.
*/
package itdst_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_IRQ_SEL    = 8'h0a;
  localparam logic [7:0] ADDR_IND_UP_LO  = 8'h16;
  localparam logic [7:0] ADDR_IND_UP_HI  = 8'h17;
  localparam logic [7:0] ADDR_IND_LOW_LO = 8'h18;
  localparam logic [7:0] ADDR_IND_LOW_HI = 8'h19;
  localparam logic [7:0] ADDR_STATUS     = 8'h20;

  // Reset values and the value read from unmapped addresses.
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [15:0] LIMIT_RESET   = 16'h0000;
  localparam logic [5:0]  IRQ_SEL_RESET = 6'h00;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;

  // Status field positions.
  localparam int ST_NO_OSC   = 7;
  localparam int ST_READY_N  = 6;
  localparam int ST_RES_HI_N = 5;
  localparam int ST_RES_HYST = 4;
  localparam int ST_IND_HI_N = 3;
  localparam int ST_IND_HYST = 2;
  localparam int ST_UNUSED   = 1;
  localparam int ST_POR      = 0;

  // Interrupt source selections that expose the latching flags, and the byte that clears them.
  localparam logic [5:0] SEL_RES_LATCH = 6'h01;
  localparam logic [5:0] SEL_IND_LATCH = 6'h08;
  localparam logic [7:0] LATCH_CLEAR   = 8'h00;

  // Power-on settling time.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int POR_TIME_NS   = 256;
  localparam int POR_CYCLES    = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POR_CNT_W     = 7;
  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);
  localparam logic [POR_CNT_W-1:0] POR_CNT_RESET = 7'h00;

  typedef enum logic [1:0] {
    POR_HOLD = 2'b01,
    POR_DONE = 2'b10
  } itdst_por_e;

  // A threshold is the high byte times 256 plus the low byte.
  function automatic logic [15:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
    join_bytes = {hi, lo};
  endfunction : join_bytes

endpackage : itdst_pkg

// ===== hw/itdst_limit_pair.sv
/*
  One 16-bit threshold built from two byte registers, the low byte buffered
  until the high byte is written. Assumes write strobes already qualified.
*/
`timescale 1ns/10ps
module itdst_limit_pair (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Byte writes
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // Buffered low byte and effective threshold
  output logic      [7:0]  low_byte,
  output logic      [15:0] limit
);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_byte <= itdst_pkg::BYTE_RESET;
    end else if (wr_low) begin
      low_byte <= wdata;
    end
  end

  // The comparators never see a half-updated threshold: both bytes move together.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      limit <= itdst_pkg::LIMIT_RESET;
    end else if (wr_high) begin
      limit <= itdst_pkg::join_bytes(wdata, low_byte);
    end
  end

endmodule : itdst_limit_pair

// ===== tb/itdst_core_model.sv
/*
  Stand-in for the conversion core that feeds the threshold and status block.
  Assumes its convert task is called from bench code running on clk.
*/
`timescale 1ns/10ps
module itdst_core_model (
  // Clock
  input  wire logic        clk,
  // Results towards the register block
  output logic             conv_done,
  output logic      [15:0] ind_result,
  output logic      [15:0] res_result,
  output logic      [15:0] res_upper_limit,
  output logic      [15:0] res_lower_limit,
  output logic             no_oscillation_error
);
  initial begin
    conv_done = 1'b0;
    ind_result = 16'h0000;
    res_result = 16'h0000;
    res_upper_limit = 16'h0200;
    res_lower_limit = 16'h0100;
    no_oscillation_error = 1'b0;
  end

  // Results only count with the pulse, so they are inverted afterwards to
  // expose a block that samples them late.
  task automatic convert(input logic [15:0] ind, input logic [15:0] res, input logic osc);
    @(negedge clk);
    conv_done = 1'b1;
    ind_result = ind;
    res_result = res;
    no_oscillation_error = osc;
    @(negedge clk);
    conv_done = 1'b0;
    ind_result = ~ind;
    res_result = ~res;
  endtask : convert
endmodule : itdst_core_model

// ===== tb/itdst_regs_bench.sv
/*
  Self-checking bench for the threshold and status register block.
  Assumes the core model drives the conversion port and the bench the register port.
*/
`timescale 1ns/10ps
module itdst_regs_bench;
  logic        clk;
  logic        rst_b;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        conv_done;
  logic [15:0] ind_result;
  logic [15:0] res_result;
  logic [15:0] res_upper_limit;
  logic [15:0] res_lower_limit;
  logic        no_oscillation_error;
  logic [15:0] ind_upper_limit;
  logic [15:0] ind_lower_limit;
  logic [5:0]  irq_source_select;
  logic        config_ready;
  logic [7:0]  st;
  int          n_errors;
  int          checks_done;
  int          i;

  itdst_regs itdst_regs_inst (
    .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_done(conv_done), .ind_result(ind_result), .res_result(res_result),
    .res_upper_limit(res_upper_limit), .res_lower_limit(res_lower_limit),
    .no_oscillation_error(no_oscillation_error), .ind_upper_limit(ind_upper_limit),
    .ind_lower_limit(ind_lower_limit), .irq_source_select(irq_source_select),
    .config_ready(config_ready)
  );

  itdst_core_model itdst_core_model_inst (
    .clk(clk), .conv_done(conv_done), .ind_result(ind_result), .res_result(res_result),
    .res_upper_limit(res_upper_limit), .res_lower_limit(res_lower_limit),
    .no_oscillation_error(no_oscillation_error)
  );

  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("reg_rvalid", {15'h0000, reg_rvalid}, 16'h0001);
    d = reg_rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, d}, {8'h00, e});
  endtask : rdchk

  task automatic stbit(input int k, input logic e, input string what);
    rd(itdst_pkg::ADDR_STATUS, st);
    chk(what, {15'h0000, st[k]}, {15'h0000, e});
  endtask : stbit

  // The status register trails a conversion by two cycles.
  task automatic conv(input logic [15:0] ind, input logic [15:0] res, input logic osc);
    itdst_core_model_inst.convert(ind, res, osc);
    repeat (2) @(negedge clk);
  endtask : conv

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #8000;
    n_errors++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    wr(itdst_pkg::ADDR_IND_LOW_HI, 8'h5a);
    stbit(itdst_pkg::ST_POR, 1'b1, "status por");
    rdchk(itdst_pkg::ADDR_IND_LOW_HI, itdst_pkg::BYTE_RESET, "early write");
    i = 0;
    st = 8'h01;
    while (st[itdst_pkg::ST_POR] !== 1'b0 && i < 60) begin
      rd(itdst_pkg::ADDR_STATUS, st);
      i++;
    end
    @(negedge clk);
    chk("config_ready", {15'h0000, config_ready}, 16'h0001);
    chk("status bit1", {15'h0000, st[itdst_pkg::ST_UNUSED]}, 16'h0000);
    rdchk(itdst_pkg::ADDR_IND_UP_HI, itdst_pkg::BYTE_RESET, "upper high reset");
    wr(itdst_pkg::ADDR_IND_LOW_LO, 8'h34);
    chk("lower limit held", ind_lower_limit, itdst_pkg::LIMIT_RESET);
    rdchk(itdst_pkg::ADDR_IND_LOW_LO, 8'h34, "lower low byte");
    wr(itdst_pkg::ADDR_IND_LOW_HI, 8'h12);
    chk("lower limit", ind_lower_limit, 16'h1234);
    wr(itdst_pkg::ADDR_IND_UP_LO, 8'h78);
    chk("upper limit held", ind_upper_limit, itdst_pkg::LIMIT_RESET);
    wr(itdst_pkg::ADDR_IND_UP_HI, 8'h56);
    chk("upper limit", ind_upper_limit, 16'h5678);
    rdchk(itdst_pkg::ADDR_IND_UP_HI, 8'h56, "upper high byte");
    wr(itdst_pkg::ADDR_STATUS, 8'hff);
    rdchk(itdst_pkg::ADDR_STATUS, 8'h68, "status write");
    rdchk(8'h40, itdst_pkg::READ_UNMAPPED, "unmapped read");
    conv(16'h1000, 16'h0180, 1'b0);
    stbit(itdst_pkg::ST_READY_N, 1'b0, "ready after conv");
    stbit(itdst_pkg::ST_IND_HYST, 1'b1, "ind below lower");
    repeat (2) @(negedge clk);
    stbit(itdst_pkg::ST_READY_N, 1'b1, "ready after read");
    conv(16'h3000, 16'h0180, 1'b0);
    stbit(itdst_pkg::ST_IND_HYST, 1'b1, "ind between");
    conv(16'h6000, 16'h0300, 1'b0);
    stbit(itdst_pkg::ST_IND_HYST, 1'b0, "ind above upper");
    stbit(itdst_pkg::ST_IND_HI_N, 1'b1, "ind latch hidden");
    stbit(itdst_pkg::ST_RES_HYST, 1'b0, "res above");
    wr(itdst_pkg::ADDR_IRQ_SEL, {2'b00, itdst_pkg::SEL_IND_LATCH});
    stbit(itdst_pkg::ST_IND_HI_N, 1'b0, "ind latch");
    rdchk(itdst_pkg::ADDR_IRQ_SEL, 8'h08, "irq select read");
    chk("irq port", {10'h000, irq_source_select}, 16'h0008);
    conv(16'h3000, 16'h0180, 1'b0);
    stbit(itdst_pkg::ST_IND_HI_N, 1'b0, "ind latch held");
    wr(itdst_pkg::ADDR_IRQ_SEL, {2'b00, itdst_pkg::SEL_RES_LATCH});
    stbit(itdst_pkg::ST_RES_HI_N, 1'b0, "res latch");
    wr(itdst_pkg::ADDR_IRQ_SEL, itdst_pkg::LATCH_CLEAR);
    wr(itdst_pkg::ADDR_IRQ_SEL, {2'b00, itdst_pkg::SEL_RES_LATCH});
    stbit(itdst_pkg::ST_RES_HI_N, 1'b1, "res latch cleared");
    wr(itdst_pkg::ADDR_IRQ_SEL, {2'b00, itdst_pkg::SEL_IND_LATCH});
    stbit(itdst_pkg::ST_IND_HI_N, 1'b1, "ind latch cleared");
    conv(16'h3000, 16'h0080, 1'b1);
    stbit(itdst_pkg::ST_RES_HYST, 1'b1, "res below lower");
    stbit(itdst_pkg::ST_NO_OSC, 1'b1, "no oscillation");
    conv(16'h3000, 16'h0080, 1'b0);
    stbit(itdst_pkg::ST_NO_OSC, 1'b0, "oscillating");
    wr(itdst_pkg::ADDR_IND_LOW_LO, 8'h00);
    wr(itdst_pkg::ADDR_IND_LOW_HI, 8'h40);
    conv(16'h3000, 16'h0080, 1'b0);
    stbit(itdst_pkg::ST_IND_HYST, 1'b1, "new lower limit");
    // A second reset must bring written registers back to their reset values.
    rst_b = 1'b0;
    @(negedge clk);
    chk("status reset", {8'h00, itdst_regs_inst.status_q}, 16'h0000);
    chk("lower reset", ind_lower_limit, itdst_pkg::LIMIT_RESET);
    chk("upper reset", ind_upper_limit, itdst_pkg::LIMIT_RESET);
    chk("ready in reset", {15'h0000, config_ready}, 16'h0000);
    rst_b = 1'b1;
    rdchk(itdst_pkg::ADDR_IND_UP_LO, itdst_pkg::BYTE_RESET, "upper low reset");
    stbit(itdst_pkg::ST_POR, 1'b1, "por again");
    give_verdict();
  end
endmodule : itdst_regs_bench
